// ===== core/tsp_timer.sv
`default_nettype none
module tsp_timer (
   input  wire logic        CLK_I,
   input  wire logic        RST_I,
   input  wire logic [3:0]  AWADDR_I,
   input  wire logic        AWVALID_I,
   output logic             AWREADY_O,
   input  wire logic [31:0] WDATA_I,
   input  wire logic [3:0]  WSTRB_I,
   input  wire logic        WVALID_I,
   output logic             WREADY_O,
   output logic [1:0]       BRESP_O,
   output logic             BVALID_O,
   input  wire logic        BREADY_I,
   input  wire logic [3:0]  ARADDR_I,
   input  wire logic        ARVALID_I,
   output logic             ARREADY_O,
   output logic [31:0]      RDATA_O,
   output logic [1:0]       RRESP_O,
   output logic             RVALID_O,
   input  wire logic        RREADY_I,
   output logic             TMR_OUT_O,
   output logic             MATCH_IRQ_O
);
   // ------------------------------------------------------------
   // Write channel capture
   // ------------------------------------------------------------
   logic       aw_have_ff;          // Write address held
   logic [3:0] aw_addr_ff;          // Held write address
   logic       w_have_ff;           // Write data held
   logic [7:0] w_data_ff;           // Held low byte of data
   logic       w_lane_ff;           // Held low-lane strobe
   logic       bvalid_ff;           // Write response pending
   logic [1:0] bresp_ff;            // Write response code
   logic       rvalid_ff;           // Read response pending
   logic [31:0] rdata_ff;           // Read data
   logic [1:0] rresp_ff;            // Read response code

   // One decode for both channels, so a register cannot be mapped on one side only
   function automatic logic is_mapped(input logic [3:0] a);
      return (a == tsp_pkg::OFS_CTL) | (a == tsp_pkg::OFS_CMP) |
             (a == tsp_pkg::OFS_CLK) | (a == tsp_pkg::OFS_STA);
   endfunction : is_mapped

   wire aw_hs = AWVALID_I & ~aw_have_ff;
   wire w_hs  = WVALID_I & ~w_have_ff;
   wire wr_go = aw_have_ff & w_have_ff & ~bvalid_ff;
   wire wr_ok = is_mapped(aw_addr_ff);
   wire wr_en  = wr_go & w_lane_ff;
   wire wr_ctl = wr_en & (aw_addr_ff == tsp_pkg::OFS_CTL);
   wire wr_cmp = wr_en & (aw_addr_ff == tsp_pkg::OFS_CMP);
   wire wr_clk = wr_en & (aw_addr_ff == tsp_pkg::OFS_CLK);

   assign AWREADY_O = ~aw_have_ff;
   assign WREADY_O  = ~w_have_ff;
   assign BVALID_O  = bvalid_ff;
   assign BRESP_O   = bresp_ff;

   // Address and data may arrive in either order; each is held until both are in
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         aw_have_ff <= 1'b0;
         aw_addr_ff <= 4'h0;
         w_have_ff  <= 1'b0;
         w_data_ff  <= 8'h00;
         w_lane_ff  <= 1'b0;
      end else begin
         aw_have_ff <= aw_hs | (aw_have_ff & ~wr_go);
         w_have_ff  <= w_hs | (w_have_ff & ~wr_go);
         if (aw_hs) begin
            aw_addr_ff <= AWADDR_I;
         end
         if (w_hs) begin
            w_data_ff <= WDATA_I[7:0];
            w_lane_ff <= WSTRB_I[0];
         end
      end
   end

   // Response follows the register update in the same edge
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= tsp_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= wr_ok ? tsp_pkg::RESP_OKAY : tsp_pkg::RESP_SLVERR;
      end else if (BREADY_I) begin
         bvalid_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------
   logic       ctl_en_ff;           // count_enable_bit
   logic       ctl_pwm_ff;          // pwm_mode_select
   logic       ctl_pol_ff;          // polarity_or_toggle_enable
   logic       ctl_oe_ff;           // output_enable_bit
   logic [7:0] cmp_buf_ff;          // compare_reg as software sees it
   logic [7:0] cmp_act_ff;          // Compare value in effect
   logic [2:0] clk_sel_ff;          // clock_select_reg

   wire nxt_lvs = w_data_ff[tsp_pkg::B_LVS];
   wire nxt_lvr = w_data_ff[tsp_pkg::B_LVR];

   // Level bits are write-only strobes, so they are never stored
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ctl_en_ff  <= tsp_pkg::CTL_RST[tsp_pkg::B_EN];
         ctl_pwm_ff <= tsp_pkg::CTL_RST[tsp_pkg::B_PWM];
         ctl_pol_ff <= tsp_pkg::CTL_RST[tsp_pkg::B_POL];
         ctl_oe_ff  <= tsp_pkg::CTL_RST[tsp_pkg::B_OE];
         cmp_buf_ff <= tsp_pkg::CMP_RST;
         clk_sel_ff <= tsp_pkg::CLK_RST;
      end else begin
         if (wr_ctl) begin
            ctl_en_ff  <= w_data_ff[tsp_pkg::B_EN];
            ctl_pwm_ff <= w_data_ff[tsp_pkg::B_PWM];
            ctl_pol_ff <= w_data_ff[tsp_pkg::B_POL];
            ctl_oe_ff  <= w_data_ff[tsp_pkg::B_OE];
         end
         if (wr_cmp) begin
            cmp_buf_ff <= w_data_ff;
         end
         if (wr_clk) begin
            clk_sel_ff <= w_data_ff[2:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Count clock
   // ------------------------------------------------------------
   logic [6:0] pre_ff;              // Free-running prescaler

   // Prescaler never stops, so a start lands anywhere in a count period
   wire [6:0] pre_mask = 7'((8'h01 << clk_sel_ff) - 8'h01);
   wire       tick     = ((pre_ff & pre_mask) == pre_mask);

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         pre_ff <= 7'h00;
      end else begin
         pre_ff <= pre_ff + 7'h01;
      end
   end

   // ------------------------------------------------------------
   // Counter and compare
   // ------------------------------------------------------------
   logic [7:0] cnt_ff;              // up_counter
   logic       pwm_run_ff;          // First overflow seen since start
   logic       tff_ff;              // Timer output flip-flop
   logic       irq_ff;              // match_interrupt pulse
   logic       out_ff;              // timer_out_pin

   wire run      = ctl_en_ff & tick;
   wire sq_match = run & ~ctl_pwm_ff & (cnt_ff == cmp_act_ff);
   wire ovf      = run & ctl_pwm_ff & (cnt_ff == tsp_pkg::CNT_MAX);
   wire pwm_lvl  = pwm_run_ff & (cnt_ff < cmp_act_ff);
   wire lvl_wr   = wr_ctl & ~w_data_ff[tsp_pkg::B_PWM] & (nxt_lvs ^ nxt_lvr);

   // Square mode clears on match; PWM wraps freely at the top
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cnt_ff <= tsp_pkg::CNT_ZERO;
      end else if (~ctl_en_ff | sq_match) begin
         cnt_ff <= tsp_pkg::CNT_ZERO;
      end else if (tick) begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end

   // Writes pass straight through unless PWM is running; then only at overflow
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cmp_act_ff <= tsp_pkg::CMP_RST;
      end else if (~ctl_pwm_ff | ~ctl_en_ff | ovf) begin
         cmp_act_ff <= cmp_buf_ff;
      end
   end

   // Inactive from start until the first wrap, and again once stopped
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         pwm_run_ff <= 1'b0;
      end else if (~ctl_en_ff | ~ctl_pwm_ff) begin
         pwm_run_ff <= 1'b0;
      end else if (ovf) begin
         pwm_run_ff <= 1'b1;
      end
   end

   // A level write outranks a toggle landing on the same edge
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         tff_ff <= 1'b0;
      end else if (lvl_wr) begin
         tff_ff <= nxt_lvs;
      end else if (sq_match & ctl_pol_ff) begin
         tff_ff <= ~tff_ff;
      end
   end

   // Pin level: disabled low, PWM level with polarity, else the flip-flop
   wire nxt_out = ~ctl_oe_ff ? 1'b0 :
                  ctl_pwm_ff ? (pwm_lvl ^ ctl_pol_ff) :
                  tff_ff;

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         out_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         out_ff <= nxt_out;
         irq_ff <= sq_match;
      end
   end

   assign TMR_OUT_O   = out_ff;
   assign MATCH_IRQ_O = irq_ff;

   // ------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------
   wire [31:0] rd_ctl = {24'h0, ctl_en_ff, ctl_pwm_ff, 4'h0, ctl_pol_ff, ctl_oe_ff};
   wire [31:0] rd_sta = {23'h0, out_ff, cnt_ff};
   wire        rd_ok  = is_mapped(ARADDR_I);
   wire [31:0] rd_mux = (ARADDR_I == tsp_pkg::OFS_CTL) ? rd_ctl :
                        (ARADDR_I == tsp_pkg::OFS_CMP) ? {24'h0, cmp_buf_ff} :
                        (ARADDR_I == tsp_pkg::OFS_CLK) ? {29'h0, clk_sel_ff} :
                        (ARADDR_I == tsp_pkg::OFS_STA) ? rd_sta : 32'h0;
   wire        ar_hs  = ARVALID_I & ~rvalid_ff;

   assign ARREADY_O = ~rvalid_ff;
   assign RVALID_O  = rvalid_ff;
   assign RDATA_O   = rdata_ff;
   assign RRESP_O   = rresp_ff;

   // One read at a time; address accepted only while no data waits
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0;
         rresp_ff  <= tsp_pkg::RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= rd_mux;
         rresp_ff  <= rd_ok ? tsp_pkg::RESP_OKAY : tsp_pkg::RESP_SLVERR;
      end else if (RREADY_I) begin
         rvalid_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   sequence pwm_start_s;
      ctl_pwm_ff & $rose(ctl_en_ff);
   endsequence

   // After a wrap the counter restarts at zero with the active phase armed
   sequence pwm_wrap_s;
      (cnt_ff == tsp_pkg::CNT_ZERO) & pwm_run_ff;
   endsequence

   oe_low_pin_a : assert property (~ctl_oe_ff |=> ~TMR_OUT_O)
      else $error("pin not low with output disabled");
   sq_clear_a : assert property (sq_match |=> (cnt_ff == tsp_pkg::CNT_ZERO) & MATCH_IRQ_O)
      else $error("square match did not clear and signal");
   sq_toggle_a : assert property (sq_match & ctl_pol_ff & ~lvl_wr |=> tff_ff != $past(tff_ff))
      else $error("flip-flop did not toggle on match");
   irq_cause_a : assert property (MATCH_IRQ_O |-> $past(sq_match))
      else $error("event pulse without a match");
   pwm_stop_a : assert property (ctl_pwm_ff & ctl_oe_ff & ~ctl_en_ff ##1 ctl_pwm_ff & ctl_oe_ff |=>
                                 TMR_OUT_O == $past(ctl_pol_ff))
      else $error("stopped PWM not inactive");
   pwm_first_a : assert property (pwm_start_s |-> ~pwm_run_ff ##1 ~pwm_lvl)
      else $error("PWM active before first overflow");
   pwm_wrap_a : assert property (ovf |=> pwm_wrap_s)
      else $error("wrap did not start active phase");
   cmp_hold_a : assert property (ctl_pwm_ff & ctl_en_ff & ~ovf |=> $stable(cmp_act_ff))
      else $error("compare changed away from overflow");
   stop_clear_a : assert property (~ctl_en_ff |=> cnt_ff == tsp_pkg::CNT_ZERO)
      else $error("counter not held at zero when stopped");
   ctl_read_a : assert property (ar_hs & (ARADDR_I == tsp_pkg::OFS_CTL) |=> RDATA_O[3:2] == 2'h0)
      else $error("level bits read nonzero");
   pwm_level_a : assert property (ctl_pwm_ff & ctl_oe_ff & pwm_run_ff & (cnt_ff < cmp_act_ff) |=>
                                  TMR_OUT_O != $past(ctl_pol_ff))
      else $error("PWM not active before match");
   pwm_idle_a : assert property (ctl_pwm_ff & ctl_oe_ff & (cnt_ff >= cmp_act_ff) |=>
                                 TMR_OUT_O == $past(ctl_pol_ff))
      else $error("PWM active after match");
endmodule : tsp_timer
`default_nettype wire

// ===== inc/tsp_pkg.sv
`default_nettype none
package tsp_pkg;
   // ------------------------------------------------------------
   // Bus geometry
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W = 4;             // Byte address width
   localparam int unsigned DATA_W = 32;            // AXI4-Lite data width
   localparam int unsigned CNT_W  = 8;             // Counter and compare width
   localparam int unsigned PRE_W  = 7;             // Prescaler width
   localparam int unsigned SEL_W  = 3;             // Clock select width
   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTL = 4'h0;   // mode_control_reg
   localparam logic [ADDR_W-1:0] OFS_CMP = 4'h4;   // compare_reg
   localparam logic [ADDR_W-1:0] OFS_CLK = 4'h8;   // clock_select_reg
   localparam logic [ADDR_W-1:0] OFS_STA = 4'hc;   // Counter and pin status
   // ------------------------------------------------------------
   // mode_control_reg and status word field positions
   // ------------------------------------------------------------
   localparam int unsigned B_EN  = 7;              // count_enable_bit
   localparam int unsigned B_PWM = 6;              // pwm_mode_select
   localparam int unsigned B_LVS = 3;              // level_set_bit
   localparam int unsigned B_LVR = 2;              // level_reset_bit
   localparam int unsigned B_POL = 1;              // polarity_or_toggle_enable
   localparam int unsigned B_OE  = 0;              // output_enable_bit
   localparam int unsigned B_STA_OUT = 8;          // Pin level in status word
   // ------------------------------------------------------------
   // Reset values and codes
   // ------------------------------------------------------------
   localparam logic [7:0]       CTL_RST = 8'h00;   // Control after reset
   localparam logic [CNT_W-1:0] CMP_RST = 8'h00;   // Compare after reset
   localparam logic [SEL_W-1:0] CLK_RST = 3'h0;    // Clock select after reset
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;  // Counter clear value
   localparam logic [CNT_W-1:0] CNT_MAX  = 8'hff;  // Last count before wrap
   localparam logic [1:0] RESP_OKAY   = 2'h0;      // AXI OKAY
   localparam logic [1:0] RESP_SLVERR = 2'h2;      // AXI SLVERR
endpackage : tsp_pkg
`default_nettype wire

// ===== verification/tsp_pin_load.sv
`default_nettype none
module tsp_pin_load (
   input  wire logic        clk_i,    // Same clock as the timer
   input  wire logic        rst_i,    // Asynchronous, active high
   input  wire logic        pin_i,    // Timer output pin level
   output logic [15:0]      hi_w_o,   // Length of last high phase in clocks
   output logic [15:0]      lo_w_o,   // Length of last low phase in clocks
   output logic [15:0]      n_edge_o  // Level changes seen so far
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------
   // Passive load: it times the phases and never drives back
   // ----------------------------------------------------------
   logic        last_ff;              // Level seen at the previous edge
   logic [15:0] run_ff;               // Clocks spent at that level so far
   // Samples like a flop would, so widths come out in whole clocks
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         last_ff  <= 1'b0;
         run_ff   <= 16'h0001;
         hi_w_o   <= 16'h0000;
         lo_w_o   <= 16'h0000;
         n_edge_o <= 16'h0000;
      end else if (pin_i !== last_ff) begin
         // Phase ended: file its length under the level it had
         if (last_ff) begin
            hi_w_o <= run_ff;
         end else begin
            lo_w_o <= run_ff;
         end
         last_ff  <= pin_i;
         run_ff   <= 16'h0001;
         n_edge_o <= n_edge_o + 16'h0001;
      end else begin
         run_ff <= run_ff + 16'h0001;
      end
   end
endmodule : tsp_pin_load
`default_nettype wire

// ===== verification/timer8_square_pwm_output_bench.sv
`default_nettype none
module timer8_square_pwm_output_bench;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------
   // Stimulus, observed outputs and bookkeeping
   // ----------------------------------------------------------
   logic        clk = 1'b0, rst = 1'b1;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, pin, irq;
   logic [1:0]  bresp, rresp;
   logic [15:0] hi_w, lo_w, n_edge;
   int          fail_count = 0, n_tests = 0, irq_run = 0, irq_gap = 0;
   // 100 MHz clock
   always #5 clk = ~clk;
   tsp_timer u_tsp_timer (.CLK_I(clk), .RST_I(rst), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
      .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready),
      .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
      .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
      .TMR_OUT_O(pin), .MATCH_IRQ_O(irq));
   tsp_pin_load u_tsp_pin_load (.clk_i(clk), .rst_i(rst), .pin_i(pin), .hi_w_o(hi_w), .lo_w_o(lo_w),
      .n_edge_o(n_edge));
   // Clocks between match pulses; a pulse every clock gives one
   always @(posedge clk) begin
      irq_run <= irq ? 1 : irq_run + 1;
      if (irq === 1'b1) begin
         irq_gap <= irq_run;
      end
   end
   // ----------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_len(input int got, input int exp);
      n_tests++;
      if (got != exp) begin
         fail_count++;
         $display("BAD %0t width %0d expected %0d", $time, got, exp);
      end
   endtask : chk_len
   // Outputs are sampled at the falling edge, where they hold what the next rising edge sees
   task automatic axi_write(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ah, wh, bh;
      logic [1:0] r;
      bh = 1'b0;
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!bh) begin
         @(negedge clk);
         ah = awvalid && awready;
         wh = wvalid && wready;
         bh = bvalid;
         r = bresp;
         @(posedge clk);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      // Let an edge pass so the next call does not raise bready in this time step
      @(posedge clk);
      chk_val({29'h0, bh, r}, {29'h0, 1'b1, er});
   endtask : axi_write
   task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ah, rh;
      logic [31:0] d;
      logic [1:0] r;
      rh = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rh) begin
         @(negedge clk);
         ah = arvalid && arready;
         rh = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ah) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      @(posedge clk);
      chk_val(d, ed);
      chk_val({29'h0, rh, r}, {29'h0, 1'b1, er});
   endtask : axi_read
   // Wait for a number of pin level changes; a stuck pin is caught by the watchdog
   task automatic wait_edges(input int k);
      logic [15:0] goal;
      goal = n_edge + 16'(k);
      while (n_edge !== goal) begin
         @(posedge clk);
      end
   endtask : wait_edges
   task automatic pin_is(input logic e);
      repeat (4) @(posedge clk);
      chk_val({31'h0, pin}, {31'h0, e});
   endtask : pin_is
   task automatic close_out();
      if (fail_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   // Reset values, then an unmapped place answers with an error and no data
   task automatic t_reset();
      chk_val({31'h0, pin}, 32'h0);
      axi_read(tsp_pkg::OFS_CTL, 32'h0, tsp_pkg::RESP_OKAY);
      axi_read(tsp_pkg::OFS_CMP, 32'h0, tsp_pkg::RESP_OKAY);
      axi_read(tsp_pkg::OFS_CLK, 32'h0, tsp_pkg::RESP_OKAY);
      axi_read(tsp_pkg::OFS_STA, 32'h0, tsp_pkg::RESP_OKAY);
      axi_write(4'h2, 8'hff, tsp_pkg::RESP_SLVERR);
      axi_read(4'h2, 32'h0, tsp_pkg::RESP_SLVERR);
   endtask : t_reset
   // Level bits preload the pin and read back as zero
   task automatic t_level();
      axi_write(tsp_pkg::OFS_CTL, 8'h07, tsp_pkg::RESP_OKAY);
      pin_is(1'b0);
      axi_read(tsp_pkg::OFS_CTL, 32'h03, tsp_pkg::RESP_OKAY);
      axi_write(tsp_pkg::OFS_CTL, 8'h0b, tsp_pkg::RESP_OKAY);
      pin_is(1'b1);
      axi_read(tsp_pkg::OFS_STA, 32'h100, tsp_pkg::RESP_OKAY);
   endtask : t_level
   // Square wave over compare boundaries and a slower count clock
   task automatic t_square();
      logic [7:0] nv [4] = '{8'h00, 8'h03, 8'h03, 8'hff};
      logic [2:0] sv [4] = '{3'h0, 3'h0, 3'h2, 3'h0};
      int e;
      for (int i = 0; i < 4; i++) begin
         e = (int'(nv[i]) + 1) << sv[i];
         axi_write(tsp_pkg::OFS_CTL, 8'h0b, tsp_pkg::RESP_OKAY);
         axi_write(tsp_pkg::OFS_CMP, nv[i], tsp_pkg::RESP_OKAY);
         axi_write(tsp_pkg::OFS_CLK, {5'h00, sv[i]}, tsp_pkg::RESP_OKAY);
         axi_write(tsp_pkg::OFS_CTL, 8'h8b, tsp_pkg::RESP_OKAY);
         wait_edges(3);
         chk_len(int'(hi_w), e);
         chk_len(int'(lo_w), e);
         chk_len(irq_gap, e);
      end
      axi_write(tsp_pkg::OFS_CTL, 8'h8a, tsp_pkg::RESP_OKAY);
      pin_is(1'b0);
      axi_write(tsp_pkg::OFS_CTL, 8'h0a, tsp_pkg::RESP_OKAY);
   endtask : t_square
   // Active-high PWM, with a compare rewrite held back until overflow
   task automatic t_pwm();
      logic [15:0] e0;                                           // Edge count before start
      axi_write(tsp_pkg::OFS_CTL, 8'h41, tsp_pkg::RESP_OKAY);
      axi_write(tsp_pkg::OFS_CMP, 8'h40, tsp_pkg::RESP_OKAY);
      axi_write(tsp_pkg::OFS_CLK, 8'h00, tsp_pkg::RESP_OKAY);
      e0 = n_edge;
      axi_write(tsp_pkg::OFS_CTL, 8'hc1, tsp_pkg::RESP_OKAY);
      repeat (150) @(posedge clk);
      chk_val({15'h0, n_edge != e0, 15'h0, pin}, 32'h0);
      wait_edges(2);
      chk_len(int'(hi_w), 64);
      wait_edges(1);
      chk_len(int'(lo_w), 192);
      axi_write(tsp_pkg::OFS_CMP, 8'h20, tsp_pkg::RESP_OKAY);
      axi_read(tsp_pkg::OFS_CMP, 32'h20, tsp_pkg::RESP_OKAY);
      wait_edges(1);
      chk_len(int'(hi_w), 64);
      wait_edges(2);
      chk_len(int'(hi_w), 32);
      axi_write(tsp_pkg::OFS_CTL, 8'h41, tsp_pkg::RESP_OKAY);
      pin_is(1'b0);
   endtask : t_pwm
   // Active-low PWM: idle high, active width still the compare value
   task automatic t_polarity();
      axi_write(tsp_pkg::OFS_CTL, 8'h43, tsp_pkg::RESP_OKAY);
      pin_is(1'b1);
      axi_write(tsp_pkg::OFS_CTL, 8'hc3, tsp_pkg::RESP_OKAY);
      wait_edges(2);
      chk_len(int'(lo_w), 32);
      axi_write(tsp_pkg::OFS_CTL, 8'h43, tsp_pkg::RESP_OKAY);
      pin_is(1'b1);
      axi_write(tsp_pkg::OFS_CTL, 8'h42, tsp_pkg::RESP_OKAY);
      pin_is(1'b0);
   endtask : t_polarity
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_level();
      t_square();
      t_pwm();
      t_polarity();
      close_out();
   end
   // Whole run needs well under 10000 clocks
   initial begin
      #400us;
      fail_count++;
      $display("BAD %0t run did not finish", $time);
      close_out();
   end
endmodule : timer8_square_pwm_output_bench
`default_nettype wire
